// ---- sim/mecs_monitor.sv ----
`timescale 1ns/100ps
module mecs_monitor #(
	parameter int SWITCH_CYCLES = 2
) (
	// Clock and resets
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        func_reset,
	// Bus side
	input wire logic [7:0]  address,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic        waitrequest,
	// Pins and levels
	input wire logic        xosc_ready_pin,
	input wire logic        fallback_req_pin,
	input wire logic        can_disabled,
	// Controls
	input wire logic [3:0]  system_clock_select_sel,
	input wire logic        xosc_en,
	input wire logic        pll_en,
	input wire logic        mvr_en,
	input wire logic [3:0]  mode,
	input wire logic        checkstop_req,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Shadows of the few registers the checks depend on
	logic        wr;
	logic [1:0]  msk;
	logic [15:0] per;
	logic        stop_mvr;
	logic [3:0]  run_m;
	assign wr = write && !waitrequest && byteenable == 4'hf;

	// Register shadows follow accepted full writes; run_m follows mode outside halt and deep stop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			msk      <= 2'h0;
			per      <= 16'h00f8;
			stop_mvr <= 1'b1;
			run_m    <= 4'h3;
		end
		else
		begin
			if (wr && address == 8'h0c)
				msk <= writedata[1:0];
			if (wr && address == 8'h10)
				per <= writedata[15:0];
			if (wr && address == 8'h68)
				stop_mvr <= writedata[7];
			if (mode != 4'h8 && mode != 4'ha)
				run_m <= mode;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// source ready first
	clk_src_ready_a: assert property (
		$changed(system_clock_select_sel) && system_clock_select_sel == 4'h2 |-> $past(xosc_ready_pin, 4))
		else $error("clock moved to crystal before it ran");
	func_rst_back_a: assert property (
		func_reset |=> mode == 4'h3 ##1 system_clock_select_sel == 4'h0)
		else $error("functional reset did not restore mode and clock");
	fallback_xosc_a: assert property (
		$rose(fallback_req_pin) && mode != 4'h2 |-> ##[2:6] !xosc_en && !pll_en)
		else $error("fallback request left crystal running");
	can_gate_a: assert property (
		$changed(mode) && per[$past(mode)] && !per[mode] |-> $past(can_disabled))
		else $error("mode left CAN enabled module");
	lp_return_a: assert property (
		$changed(mode) && $past(mode) inside {4'h8, 4'ha} && mode != 4'h3
		|-> mode == run_m)
		else $error("low power exit to wrong run mode");
	bad_cfg_flag_a: assert property (
		wr && address[7:6] == 2'b01 && writedata[6] && !writedata[5] && msk[1]
		|-> ##[1:3] irq)
		else $error("invalid configuration not flagged");
	stop_mvr_a: assert property (
		$changed(mode) && mode == 4'ha |-> mvr_en == stop_mvr)
		else $error("regulator not per deep stop config");
	chkstop_rst_a: assert property (
		checkstop_req |-> ##[1:3] mode == 4'h3)
		else $error("checkstop without reset to default run");
endmodule : mecs_monitor

bind mecs_top mecs_monitor #(.SWITCH_CYCLES(SWITCH_CYCLES)) u_monitor (
	.clk(clk), .rst(rst), .func_reset(func_reset), .address(address),
	.write(write), .writedata(writedata), .byteenable(byteenable),
	.waitrequest(waitrequest), .xosc_ready_pin(xosc_ready_pin),
	.fallback_req_pin(fallback_req_pin), .can_disabled(can_disabled),
	.system_clock_select_sel(system_clock_select_sel), .xosc_en(xosc_en), .pll_en(pll_en),
	.mvr_en(mvr_en), .mode(mode), .checkstop_req(checkstop_req), .irq(irq));

// ---- sim/tb_mecs_top.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_mecs_top;
	// Design ports
	logic        clk, rst, func_reset, read, write, waitrequest;
	logic [7:0]  address;
	logic [31:0] writedata, readdata;
	logic [3:0]  byteenable, system_clock_select_sel, mode;
	logic        firc_ready_pin, xosc_ready_pin, pll_ready_pin;
	logic        fallback_req_pin, wakeup_pin, irq_pending, can_disabled;
	logic        xosc_en, firc_en, pll_en, mvr_en, flash_en, can_clk_en;
	logic        checkstop_req, irq;
	// Bench state
	int          failures, samples_checked, n;
	logic [31:0] rdv;
	logic [3:0]  m;
	logic [15:0] k;

	mecs_top #(.SWITCH_CYCLES(2)) DUT (
		.clk(clk), .rst(rst), .func_reset(func_reset), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .firc_ready_pin(firc_ready_pin),
		.xosc_ready_pin(xosc_ready_pin), .pll_ready_pin(pll_ready_pin),
		.fallback_req_pin(fallback_req_pin), .wakeup_pin(wakeup_pin),
		.irq_pending(irq_pending), .can_disabled(can_disabled),
		.system_clock_select_sel(system_clock_select_sel), .xosc_en(xosc_en), .firc_en(firc_en),
		.pll_en(pll_en), .mvr_en(mvr_en), .flash_en(flash_en),
		.can_clk_en(can_clk_en), .mode(mode),
		.checkstop_req(checkstop_req), .irq(irq));

	////////////////////////////////////////////////////////////////////////
	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int t;
		t = 0;
		@(posedge clk);
		address   <= a;
		writedata <= d;
		write     <= w;
		read      <= !w;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (waitrequest !== 1'b0 && t < 50);
		q = readdata;
		if (t >= 50)
			failures++;
		write <= 1'b0;
		read  <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	function automatic logic [31:0] key_w(input logic [3:0] md,
		input logic [15:0] ky);
		return {md, 12'h000, ky};
	endfunction : key_w

	// Mode configuration word from its fields
	function automatic logic [31:0] cfg(input logic [3:0] c,
		input logic fi, xo, pl, mv, fl);
		return {23'h0, fl, mv, pl, xo, fi, c};
	endfunction : cfg

	// key write, then inverted key write
	task automatic req(input logic [3:0] md);
		wr(8'h00, key_w(md, 16'h5af0));
		wr(8'h00, key_w(md, 16'ha50f));
	endtask : req

	// Poll transition-active, bounded so a hang shows as a failure
	task automatic idle();
		int t;
		t = 0;
		do
		begin
			bus(1'b0, 8'h04, 32'h0, rdv);
			t++;
		end
		while (rdv[27] !== 1'b0 && t < 100);
		if (rdv[27] !== 1'b0)
			failures++;
	endtask : idle

	task automatic wait_mode(input logic [3:0] want);
		int t;
		for (t = 0; t < 300 && mode !== want; t++)
			@(posedge clk);
		if (mode !== want)
			failures++;
	endtask : wait_mode

	task automatic give_verdict();
		if (failures == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	// Free-running 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Watchdog well above the run's few hundred cycles
	initial
	begin
		#40000;
		failures++;
		give_verdict();
	end

	initial
	begin
		{rst, byteenable} = 5'h1f;
		{func_reset, read, write, address, writedata} = '0;
		{firc_ready_pin, pll_ready_pin, xosc_ready_pin} = 3'b110;
		{fallback_req_pin, wakeup_pin, irq_pending, can_disabled} = 4'h0;
		void'($urandom(32'h857d));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 8'h04, 32'h0, rdv);
		`CHK(rdv[31:26], 6'h0c)
		`CHK(rdv[3:0], 4'h0)
		wr(8'h0c, 32'h3);
		for (int i = 0; i < 4; i++)
		begin
			m = 4'h4 + 4'($urandom_range(3));
			k = 16'($urandom);
			if (k == 16'ha50f)
				k = 16'h0;
			wr(8'h00, key_w(m, 16'h5af0));
			if (i == 0)
				wr(8'h0c, 32'h3);
			wr(8'h00, key_w(m, (i == 0) ? 16'ha50f : k));
			bus(1'b0, 8'h04, 32'h0, rdv);
			`CHK(rdv[31:27], 5'h06)
		end
		wr(8'h5c, cfg(4'h2, 1, 1, 0, 1, 1));
		req(4'h7);
		repeat (20) @(posedge clk);
		bus(1'b0, 8'h04, 32'h0, rdv);
		`CHK(rdv[27], 1'b1)
		`CHK(system_clock_select_sel, 4'h0)
		xosc_ready_pin <= 1'b1;
		idle();
		`CHK(mode, 4'h7)
		`CHK(system_clock_select_sel, 4'h2)
		`CHK(irq, 1'b1)
		// run mode entered twice before low power
		req(4'h7);
		idle();
		wr(8'h08, 32'h3);
		wr(8'h50, cfg(4'h4, 1, 0, 1, 1, 1));
		bus(1'b0, 8'h08, 32'h0, rdv);
		`CHK(rdv[1:0], 2'b10)
		wr(8'h08, 32'h2);
		req(4'h4);
		repeat (10) @(posedge clk);
		bus(1'b0, 8'h08, 32'h0, rdv);
		`CHK(rdv[1:0], 2'b10)
		`CHK(mode, 4'h7)
		wr(8'h08, 32'h3);
		// crystal left on in deep stop mode, so the regulator case bites
		wr(8'h68, cfg(4'h2, 0, 1, 0, 0, 1));
		req(4'ha);
		repeat (30) @(posedge clk);
		`CHK(mode, 4'h7)
		can_disabled <= 1'b1;
		wait_mode(4'ha);
		`CHK(mvr_en, 1'b0)
		`CHK({firc_en, flash_en}, 2'b01)
		`CHK(can_clk_en, 1'b0)
		irq_pending <= 1'b1;
		wait_mode(4'h7);
		irq_pending <= 1'b0;
		`CHK(mode, 4'h7)
		`CHK(can_clk_en, 1'b1)
		idle();
		// flash off and entry not run from RAM on purpose
		wr(8'h68, cfg(4'h2, 0, 1, 0, 0, 0));
		wr(8'h00, key_w(4'ha, 16'h5af0));
		wakeup_pin <= 1'b1;
		wr(8'h00, key_w(4'ha, 16'ha50f));
		for (n = 0; n < 20 && checkstop_req !== 1'b1; n++)
			@(posedge clk);
		`CHK(checkstop_req, 1'b1)
		wakeup_pin <= 1'b0;
		wait_mode(4'h3);
		bus(1'b0, 8'h14, 32'h0, rdv);
		`CHK(rdv[0], 1'b1)
		req(4'h7);
		idle();
		// fallback raised only once the switch is done
		fallback_req_pin <= 1'b1;
		for (n = 0; n < 8 && xosc_en !== 1'b0; n++)
			@(posedge clk);
		`CHK({xosc_en, pll_en}, 2'b00)
		wait_mode(4'h2);
		fallback_req_pin <= 1'b0;
		`CHK(mode, 4'h2)
		// switch stalls on a crystal that stops, reset recovers
		xosc_ready_pin <= 1'b0;
		// Synced fallback level must fall before the next key
		repeat (4) @(posedge clk);
		req(4'h7);
		// Crystal runs two cycles only: gone mid-switch
		xosc_ready_pin <= 1'b1;
		repeat (2) @(posedge clk);
		xosc_ready_pin <= 1'b0;
		repeat (10) @(posedge clk);
		bus(1'b0, 8'h04, 32'h0, rdv);
		`CHK(rdv[27:26], 2'b11)
		@(posedge clk);
		func_reset <= 1'b1;
		@(posedge clk);
		func_reset <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(mode, 4'h3)
		`CHK(system_clock_select_sel, 4'h0)
		bus(1'b0, 8'h14, 32'h0, rdv);
		`CHK(rdv[1], 1'b1)
		// Switching works again after the reset
		xosc_ready_pin <= 1'b1;
		req(4'h7);
		idle();
		`CHK({mode, system_clock_select_sel}, 8'h72)
		give_verdict();
	end
endmodule : tb_mecs_top

// ---- src/mecs_cfg.svh ----
`ifndef MECS_CFG_SVH
`define MECS_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets, one aligned word each
`define MECS_OFS_MODE_CTRL  8'h00
`define MECS_OFS_STATUS     8'h04
`define MECS_OFS_IRQ_STAT   8'h08
`define MECS_OFS_IRQ_MASK   8'h0c
`define MECS_OFS_PERIPH     8'h10
`define MECS_OFS_RST_STAT   8'h14
// Mode configuration words, one per mode code, 0x40 to 0x7c
`define MECS_CFG_REGION     2'b01

////////////////////////////////////////////////////////////////////////////
// Mode control word layout and keys
`define MECS_MC_MODE_MSB    31
`define MECS_MC_MODE_LSB    28
`define MECS_KEY            16'h5af0
`define MECS_KEY_INV        16'ha50f

// Mode codes
`define MECS_MODE_FALLBACK  4'h2
`define MECS_MODE_DEFAULT_RUN_MODE      4'h3
`define MECS_MODE_RUN0      4'h4
`define MECS_MODE_RUN_MODE_THREE      4'h7
`define MECS_MODE_HALT_MODE_ZERO     4'h8
`define MECS_MODE_DEEP_STOP_MODE     4'ha

////////////////////////////////////////////////////////////////////////////
// Mode configuration fields
`define MECS_CFG_W          9
`define MECS_CFG_CLK_MSB    3
`define MECS_CFG_CLK_LSB    0
`define MECS_CFG_FIRC       4
`define MECS_CFG_XOSC       5
`define MECS_CFG_PLL        6
`define MECS_CFG_MVR        7
`define MECS_CFG_FLASH      8
`define MECS_CFG_RST        9'h190

// System clock source codes
`define MECS_CLK_FIRC       4'h0
`define MECS_CLK_XOSC       4'h2
`define MECS_CLK_XOSC_DIV   4'h3
`define MECS_CLK_PLL        4'h4
`define MECS_CLK_OFF        4'hf

////////////////////////////////////////////////////////////////////////////
// Status fields, reset values and counts
`define MECS_IRQ_DONE       0
`define MECS_IRQ_ICONF      1
`define MECS_RS_CHKSTOP     0
`define MECS_RS_FUNC        1
`define MECS_PERIPH_RST     16'h00f8
`define MECS_SWITCH_CYCLES  2
`define MECS_CHKSTOP_WIN    3'h4

`endif

// ---- src/mecs_clk_switch.sv ----
`timescale 1ns/100ps
`include "mecs_cfg.svh"
module mecs_clk_switch #(
	parameter int SWITCH_CYCLES = `MECS_SWITCH_CYCLES
) (
	// Clock and resets
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        soft_rst,
	// Switch request
	input  wire logic        start,
	input  wire logic [3:0]  target,
	input  wire logic [15:0] avail,
	// Result
	output logic      [3:0]  sel,
	output logic             done,
	output logic             stalled
);

	typedef struct packed {
		mecs_pkg::mecs_cs_st_t st;
		logic [3:0]            sel;
		logic [3:0]            tgt;
		logic [1:0]            cnt;
		logic                  done;
		logic                  stalled;
	} mecs_cs_t;

	mecs_cs_t q;
	mecs_cs_t next_q;

	// Verify the target first, then move over while it keeps running
	always_comb
	begin
		next_q = q;
		next_q.done = 1'b0;
		case (q.st)
			mecs_pkg::CS_IDLE, mecs_pkg::CS_VERIFY, mecs_pkg::CS_SWITCH:
			begin
				if (start)
				begin
					next_q.tgt = target;
					next_q.st = mecs_pkg::CS_VERIFY;
				end
				else if (q.st == mecs_pkg::CS_VERIFY && avail[q.tgt])
				begin
					next_q.cnt = 2'h0;
					next_q.st = mecs_pkg::CS_SWITCH;
				end
				// Target died mid-switch: only a reset gets out of this
				else if (q.st == mecs_pkg::CS_SWITCH && !avail[q.tgt])
				begin
					next_q.st = mecs_pkg::CS_STALL;
					next_q.stalled = 1'b1;
				end
				else if (q.st == mecs_pkg::CS_SWITCH &&
					q.cnt == 2'(SWITCH_CYCLES - 1))
				begin
					next_q.sel = q.tgt;
					next_q.done = 1'b1;
					next_q.st = mecs_pkg::CS_IDLE;
				end
				else if (q.st == mecs_pkg::CS_SWITCH)
					next_q.cnt = q.cnt + 2'h1;
			end
			mecs_pkg::CS_STALL:
				next_q.stalled = 1'b1;
			default:
				next_q.st = mecs_pkg::CS_IDLE;
		endcase
		if (soft_rst)
		begin
			next_q.st = mecs_pkg::CS_IDLE;
			next_q.sel = `MECS_CLK_FIRC;
			next_q.stalled = 1'b0;
			next_q.done = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q.st <= mecs_pkg::CS_IDLE;
			q.sel <= `MECS_CLK_FIRC;
			q.tgt <= `MECS_CLK_FIRC;
			q.cnt <= 2'h0;
			q.done <= 1'b0;
			q.stalled <= 1'b0;
		end
		else
			q <= next_q;
	end

	assign sel = q.sel;
	assign done = q.done;
	assign stalled = q.stalled;

endmodule : mecs_clk_switch

// ---- src/mecs_pkg.sv ----
package mecs_pkg;

	// Mode sequencer states
	typedef enum logic [3:0] {
		MS_IDLE  = 4'b0001,
		MS_KEYED = 4'b0010,
		MS_TRANS = 4'b0100,
		MS_LPM   = 4'b1000
	} mecs_mode_st_t;

	// Clock switch states
	typedef enum logic [3:0] {
		CS_IDLE   = 4'b0001,
		CS_VERIFY = 4'b0010,
		CS_SWITCH = 4'b0100,
		CS_STALL  = 4'b1000
	} mecs_cs_st_t;

endpackage : mecs_pkg

// ---- src/mecs_sync.sv ----
`timescale 1ns/100ps
module mecs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Asynchronous levels in, filtered levels out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} mecs_sync_t;

	mecs_sync_t q;
	mecs_sync_t next_q;

	// Output follows only where second and third stage agree
	always_comb
	begin
		next_q = q;
		next_q.s1 = async_in;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		next_q.out = (q.s3 & ~(q.s2 ^ q.s3)) | (q.out & (q.s2 ^ q.s3));
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= next_q;
	end

	assign sync_out = q.out;

endmodule : mecs_sync

// ---- src/mecs_top.sv ----
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "mecs_cfg.svh"
module mecs_top #(
	parameter int SWITCH_CYCLES = `MECS_SWITCH_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        func_reset,
	// Avalon-MM slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Asynchronous pins: firc, xosc, pll ready, fallback, wakeup
	input  wire logic        firc_ready_pin,
	input  wire logic        xosc_ready_pin,
	input  wire logic        pll_ready_pin,
	input  wire logic        fallback_req_pin,
	input  wire logic        wakeup_pin,
	// Same-domain inputs
	input  wire logic        irq_pending,
	input  wire logic        can_disabled,
	// Clock, power and peripheral controls
	output logic      [3:0]  system_clock_select_sel,
	output logic             xosc_en,
	output logic             firc_en,
	output logic             pll_en,
	output logic             mvr_en,
	output logic             flash_en,
	output logic             can_clk_en,
	output logic      [3:0]  mode,
	output logic             checkstop_req,
	output logic             irq
);

	typedef struct packed {
		mecs_pkg::mecs_mode_st_t                 mst;
		logic [3:0]                              cur_mode;
		logic [3:0]                              tgt_mode;
		logic [3:0]                              ret_mode;
		logic                                    active;
		logic                                    cs_start;
		logic                                    cs_ok;
		logic                                    soft_rst;
		logic [2:0]                              win_cnt;
		logic [1:0]                              irq_stat;
		logic [1:0]                              irq_mask;
		logic [15:0]                             periph;
		logic [15:0][`MECS_CFG_W-1:0]            cfg;
		logic                                    chk_flag;
		logic                                    func_flag;
		logic                                    waitreq;
		logic [31:0]                             rdata;
		logic                                    xosc_en;
		logic                                    firc_en;
		logic                                    pll_en;
		logic                                    mvr_en;
		logic                                    flash_en;
		logic                                    can_clk_en;
		logic                                    chk_req;
		logic                                    irq;
	} mecs_top_t;

	mecs_top_t             q;
	mecs_top_t             next_q;
	logic [2:0]            pin_s;
	logic                  fb_s;
	logic                  wake_s;
	logic [15:0]           avail;
	logic [3:0]            cs_sel;
	logic                  cs_done;
	logic                  cs_stall;
	logic [`MECS_CFG_W-1:0] tcfg;
	logic [`MECS_CFG_W-1:0] wcfg;
	logic [3:0]            req_mode;
	logic                  wr_full;
	logic                  mc_wr;
	logic                  key1;
	logic                  key2;
	logic                  tgt_lp;
	logic                  can_block;
	logic [31:0]           rd_mux;
	logic                  do_start;
	logic [3:0]            start_mode;
	logic [1:0]            irq_set;
	logic                  chk;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and clock switch

	mecs_sync #(.W(5)) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in ({wakeup_pin, fallback_req_pin, pll_ready_pin,
			xosc_ready_pin, firc_ready_pin}),
		.sync_out ({wake_s, fb_s, pin_s})
	);

	// Source availability by clock code; off is always reachable
	assign avail = {1'b1, 10'h000, pin_s[2], pin_s[1], pin_s[1],
		1'b0, pin_s[0]};

	mecs_clk_switch #(.SWITCH_CYCLES(SWITCH_CYCLES)) u_cs (
		.clk      (clk),
		.rst      (rst),
		.soft_rst (q.soft_rst),
		.start    (q.cs_start),
		.target   (tcfg[`MECS_CFG_CLK_MSB:`MECS_CFG_CLK_LSB]),
		.avail    (avail),
		.sel      (cs_sel),
		.done     (cs_done),
		.stalled  (cs_stall)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus decode helpers

	assign tcfg = q.cfg[q.tgt_mode];
	assign wcfg = writedata[`MECS_CFG_W-1:0];
	assign req_mode = writedata[`MECS_MC_MODE_MSB:`MECS_MC_MODE_LSB];
	// Partial-word writes are dropped
	assign wr_full = write && !q.waitreq && byteenable == 4'hf;
	assign mc_wr = wr_full && address == `MECS_OFS_MODE_CTRL;
	assign key1 = mc_wr && writedata[15:0] == `MECS_KEY;
	assign key2 = mc_wr && writedata[15:0] == `MECS_KEY_INV;
	assign tgt_lp = q.tgt_mode == `MECS_MODE_HALT_MODE_ZERO ||
		q.tgt_mode == `MECS_MODE_DEEP_STOP_MODE;
	// hold completion while CAN still runs
	assign can_block = q.periph[q.cur_mode] && !q.periph[q.tgt_mode] &&
		!can_disabled;

	// Read mux, unmapped words read zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (address[7:6] == `MECS_CFG_REGION)
			rd_mux = {23'h000000, q.cfg[address[5:2]]};
		else
			case (address)
				`MECS_OFS_MODE_CTRL: rd_mux = {q.tgt_mode, 28'h0000000};
				`MECS_OFS_STATUS: rd_mux = {q.cur_mode, q.active, cs_stall,
					22'h000000, cs_sel};
				`MECS_OFS_IRQ_STAT: rd_mux = {30'h00000000, q.irq_stat};
				`MECS_OFS_IRQ_MASK: rd_mux = {30'h00000000, q.irq_mask};
				`MECS_OFS_PERIPH: rd_mux = {16'h0000, q.periph};
				`MECS_OFS_RST_STAT: rd_mux = {30'h00000000, q.func_flag,
					q.chk_flag};
				default: rd_mux = 32'h0000_0000;
			endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		next_q = q;
		do_start = 1'b0;
		start_mode = q.tgt_mode;
		irq_set = 2'b00;
		chk = 1'b0;
		next_q.cs_start = 1'b0;
		next_q.soft_rst = 1'b0;
		next_q.chk_req = 1'b0;

		// One wait cycle per access, answer in the second
		next_q.waitreq = !((read || write) && q.waitreq);
		if (read && q.waitreq)
			next_q.rdata = rd_mux;

		// Plain register writes
		if (wr_full && address[7:6] == `MECS_CFG_REGION)
		begin
			next_q.cfg[address[5:2]] = wcfg;
			// flag invalid oscillator and pll pairing
			if (wcfg[`MECS_CFG_PLL] && !wcfg[`MECS_CFG_XOSC])
				irq_set[`MECS_IRQ_ICONF] = 1'b1;
		end
		if (wr_full && address == `MECS_OFS_IRQ_MASK)
			next_q.irq_mask = writedata[1:0];
		if (wr_full && address == `MECS_OFS_PERIPH)
			next_q.periph = writedata[15:0];

		// Mode sequencer
		case (q.mst)
			mecs_pkg::MS_IDLE:
			begin
				if (key1)
				begin
					next_q.tgt_mode = req_mode;
					next_q.mst = mecs_pkg::MS_KEYED;
				end
			end
			mecs_pkg::MS_KEYED:
			begin
				// wrong second write drops the sequence
				if (wr_full)
					next_q.mst = mecs_pkg::MS_IDLE;
				if (key2 && req_mode == q.tgt_mode)
				begin
					if (tcfg[`MECS_CFG_PLL] && !tcfg[`MECS_CFG_XOSC])
						irq_set[`MECS_IRQ_ICONF] = 1'b1;
					else
						do_start = 1'b1;
				end
			end
			mecs_pkg::MS_TRANS:
			begin
				if (q.win_cnt != 3'h0)
					next_q.win_cnt = q.win_cnt - 3'h1;
				if (cs_done)
					next_q.cs_ok = 1'b1;
				// Keep old sources on until the new clock is in place
				next_q.firc_en = q.firc_en | tcfg[`MECS_CFG_FIRC];
				next_q.xosc_en = q.xosc_en | tcfg[`MECS_CFG_XOSC];
				next_q.pll_en = q.pll_en | tcfg[`MECS_CFG_PLL];
				next_q.flash_en = q.flash_en | tcfg[`MECS_CFG_FLASH];
				next_q.mvr_en = q.mvr_en | tcfg[`MECS_CFG_MVR];
				if (q.tgt_mode == `MECS_MODE_FALLBACK)
				begin
					next_q.xosc_en = 1'b0;
					next_q.pll_en = 1'b0;
				end
				// complete only with clock and CAN settled
				if (q.cs_ok && !can_block)
				begin
					next_q.cur_mode = q.tgt_mode;
					next_q.active = 1'b0;
					irq_set[`MECS_IRQ_DONE] = 1'b1;
					next_q.firc_en = tcfg[`MECS_CFG_FIRC];
					next_q.xosc_en = tcfg[`MECS_CFG_XOSC];
					next_q.pll_en = tcfg[`MECS_CFG_PLL];
					next_q.flash_en = tcfg[`MECS_CFG_FLASH];
					next_q.mvr_en = tcfg[`MECS_CFG_MVR];
					next_q.can_clk_en = q.periph[q.tgt_mode];
					next_q.mst = tgt_lp ? mecs_pkg::MS_LPM : mecs_pkg::MS_IDLE;
				end
				// early wakeup while flash powers down
				if (q.win_cnt != 3'h0 && wake_s && tgt_lp &&
					!tcfg[`MECS_CFG_FLASH])
					chk = 1'b1;
			end
			mecs_pkg::MS_LPM:
			begin
				// wake back into the requesting run mode
				if (wake_s || irq_pending)
				begin
					do_start = 1'b1;
					start_mode = q.ret_mode;
				end
			end
			default:
				next_q.mst = mecs_pkg::MS_IDLE;
		endcase

		if (fb_s && q.tgt_mode != `MECS_MODE_FALLBACK)
		begin
			do_start = 1'b1;
			start_mode = `MECS_MODE_FALLBACK;
		end

		// Launch a transition
		if (do_start)
		begin
			next_q.tgt_mode = start_mode;
			// active from the taken request onward
			next_q.active = 1'b1;
			next_q.cs_start = 1'b1;
			next_q.cs_ok = 1'b0;
			next_q.mst = mecs_pkg::MS_TRANS;
			next_q.win_cnt = `MECS_CHKSTOP_WIN;
			// remember the run mode asking for low power
			if (start_mode == `MECS_MODE_HALT_MODE_ZERO ||
				start_mode == `MECS_MODE_DEEP_STOP_MODE)
				next_q.ret_mode = q.cur_mode;
			// crystal off in the very cycle after the request
			if (start_mode == `MECS_MODE_FALLBACK)
			begin
				next_q.xosc_en = 1'b0;
				next_q.pll_en = 1'b0;
			end
		end

		// functional reset or checkstop returns to default run
		if (chk || func_reset)
		begin
			next_q.mst = mecs_pkg::MS_IDLE;
			next_q.cur_mode = `MECS_MODE_DEFAULT_RUN_MODE;
			next_q.tgt_mode = `MECS_MODE_DEFAULT_RUN_MODE;
			next_q.active = 1'b0;
			next_q.cs_start = 1'b0;
			next_q.cs_ok = 1'b0;
			next_q.soft_rst = 1'b1;
			next_q.win_cnt = 3'h0;
			next_q.firc_en = 1'b1;
			next_q.xosc_en = 1'b0;
			next_q.pll_en = 1'b0;
			next_q.mvr_en = 1'b1;
			next_q.flash_en = 1'b1;
			next_q.can_clk_en = q.periph[`MECS_MODE_DEFAULT_RUN_MODE];
		end

		// checkstop flag; set wins over clear on every sticky bit
		next_q.chk_req = chk;
		next_q.chk_flag = (q.chk_flag & !(wr_full &&
			address == `MECS_OFS_RST_STAT && writedata[`MECS_RS_CHKSTOP]))
			| chk;
		next_q.func_flag = (q.func_flag & !(wr_full &&
			address == `MECS_OFS_RST_STAT && writedata[`MECS_RS_FUNC]))
			| func_reset;
		next_q.irq_stat = (q.irq_stat & ~((wr_full &&
			address == `MECS_OFS_IRQ_STAT) ? writedata[1:0] : 2'b00))
			| irq_set;
		next_q.irq = |(next_q.irq_stat & next_q.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.mst <= mecs_pkg::MS_IDLE;
			q.cur_mode <= `MECS_MODE_DEFAULT_RUN_MODE;
			q.tgt_mode <= `MECS_MODE_DEFAULT_RUN_MODE;
			q.ret_mode <= `MECS_MODE_DEFAULT_RUN_MODE;
			q.periph <= `MECS_PERIPH_RST;
			q.cfg <= {16{`MECS_CFG_RST}};
			q.waitreq <= 1'b1;
			q.firc_en <= 1'b1;
			q.mvr_en <= 1'b1;
			q.flash_en <= 1'b1;
			q.can_clk_en <= 1'b1;
		end
		else
			q <= next_q;
	end

	// Outputs straight from flip-flops
	assign readdata = q.rdata;
	assign waitrequest = q.waitreq;
	assign system_clock_select_sel = cs_sel;
	assign xosc_en = q.xosc_en;
	assign firc_en = q.firc_en;
	assign pll_en = q.pll_en;
	assign mvr_en = q.mvr_en;
	assign flash_en = q.flash_en;
	assign can_clk_en = q.can_clk_en;
	assign mode = q.cur_mode;
	assign checkstop_req = q.chk_req;
	assign irq = q.irq;

endmodule : mecs_top
